// ===== src/tfd_map.svh
// Purpose: Offsets, field positions and reset values of the timer unit
// Assumes: APB byte addresses, 32-bit words, 8 channels
// Notes: Included by the unit top and the channel module
// Behaviour
// - Power off: clock stopped, writes ignored except power, port direction and latch
// - Power on: writes accepted, channels stopped
// - Prescaler sets both shared count clock rates
// - Output mode and level zero: toggle
// - Pin drives level only in output direction
// - Start trigger sets enable, reads zero
// - First count clock loads data, optional event
// - Count down, reload at zero, keep running
// - Zero detect raises interrupt, toggles output
// - Data, output enable and value regs writable; counter always readable
// - Channel status register unused, no effect
// - Stop trigger clears enable, counter holds
// - Stop keeps present output level
// - Output disabled: pin follows software value
// - Power off clears channels and output value
// - Eight identical channels with own pins
`ifndef TFD_MAP_SVH
`define TFD_MAP_SVH

`define TFD_ADDR_PWR 8'h00
`define TFD_ADDR_PSC 8'h04
`define TFD_ADDR_ENST 8'h08
`define TFD_ADDR_START 8'h0c
`define TFD_ADDR_STOP 8'h10
`define TFD_ADDR_OEN 8'h14
`define TFD_ADDR_OVAL 8'h18
`define TFD_ADDR_OLVL 8'h1c
`define TFD_ADDR_OMODE 8'h20
`define TFD_ADDR_IST 8'h24
`define TFD_ADDR_IMASK 8'h28
`define TFD_ADDR_PDIR 8'h2c
`define TFD_ADDR_PLAT 8'h30
`define TFD_ADDR_PIN 8'h34
`define TFD_GRP_MODE 3'h2
`define TFD_GRP_DATA 3'h3
`define TFD_GRP_CNT 3'h4
`define TFD_GRP_STAT 3'h5

`define TFD_PWR_BIT 0
`define TFD_MODE_MD_BIT 0
`define TFD_MODE_CKS_BIT 1

`define TFD_RST_PSC 8'h00
`define TFD_RST_PDIR 8'hff
`define TFD_RST_PLAT 8'h00
`define TFD_RST_CNT 16'h0000

`endif

// ===== src/tfd_pkg.sv
// Purpose: Types shared by the timer unit files
// Assumes: Nothing beyond SystemVerilog
// Notes: Offsets live in tfd_map.svh
`default_nettype none
package tfd_pkg;
    typedef enum logic [2:0] {
        TFD_STOP = 3'b001,
        TFD_LOAD = 3'b010,
        TFD_RUN = 3'b100
    } tfd_ch_state_t;
endpackage
`default_nettype wire

// ===== src/tfd_channel.sv
// Purpose: One down-counting interval channel with auto reload
// Assumes: tick is a one-cycle count clock enable from the prescaler
// Notes: Stop beats start in the same cycle
`include "tfd_map.svh"
`default_nettype none
module tfd_channel (
    input wire logic clock,
    input wire logic resetn,
    input wire logic unit_on,
    input wire logic start,
    input wire logic stop,
    input wire logic tick,
    input wire logic start_irq_mode,
    input wire logic [15:0] data,
    output logic running,
    output logic [15:0] count,
    output logic zero_evt
);
    tfd_pkg::tfd_ch_state_t state_r;
    logic go;

    assign go = tick & ~stop;
    assign running = (state_r != tfd_pkg::TFD_STOP);

    always_ff @(posedge clock) begin
        if (!resetn || !unit_on) begin
            state_r <= tfd_pkg::TFD_STOP;
        end else if (stop) begin
            state_r <= tfd_pkg::TFD_STOP;
        end else if (start) begin
            state_r <= tfd_pkg::TFD_LOAD;
        end else if (go && state_r == tfd_pkg::TFD_LOAD) begin
            state_r <= tfd_pkg::TFD_RUN;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || !unit_on) begin
            count <= `TFD_RST_CNT;
        end else if (go && !start) begin
            unique case (state_r)
                tfd_pkg::TFD_LOAD: count <= data;
                tfd_pkg::TFD_RUN: begin
                    if (count == 16'h0000) begin
                        count <= data;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                tfd_pkg::TFD_STOP: count <= count;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || !unit_on) begin
            zero_evt <= 1'b0;
        end else begin
            zero_evt <= go && !start &&
                ((state_r == tfd_pkg::TFD_LOAD && start_irq_mode) ||
                 (state_r == tfd_pkg::TFD_RUN && count == 16'h0000));
        end
    end

    sequence s_live_tick;
        unit_on && go && !start;
    endsequence

    sequence s_zero_tick;
        s_live_tick and (state_r == tfd_pkg::TFD_RUN && count == 16'h0000);
    endsequence

    a_start_runs: assert property (
        @(posedge clock) disable iff (!resetn)
        unit_on && start && !stop |=> running && state_r == tfd_pkg::TFD_LOAD)
        else $error("start trigger did not enable channel");

    a_load_first: assert property (
        @(posedge clock) disable iff (!resetn)
        s_live_tick and state_r == tfd_pkg::TFD_LOAD
        |=> count == $past(data) && zero_evt == $past(start_irq_mode))
        else $error("first count clock did not load data");

    a_count_down: assert property (
        @(posedge clock) disable iff (!resetn)
        s_live_tick and (state_r == tfd_pkg::TFD_RUN && count != 16'h0000)
        |=> count == $past(count) - 16'h0001 && !zero_evt)
        else $error("counter did not decrement");

    a_zero_reload: assert property (
        @(posedge clock) disable iff (!resetn)
        s_zero_tick |=> count == $past(data) && zero_evt && running)
        else $error("zero detect missed reload or event");

    a_stop_holds: assert property (
        @(posedge clock) disable iff (!resetn)
        unit_on && stop |=> !running && count == $past(count))
        else $error("stop did not freeze counter");

    a_off_clears: assert property (
        @(posedge clock) disable iff (!resetn)
        !unit_on |=> !running && count == `TFD_RST_CNT && !zero_evt)
        else $error("power off left channel state");
endmodule // tfd_channel
`default_nettype wire

// ===== src/tfd_top.sv
// Purpose: Eight channel timer unit run as frequency dividers, APB slave
// Assumes: Single 20 MHz clock, zero wait APB, synchronous low reset
// Notes: Port direction and latch regs survive unit power off
`include "tfd_map.svh"
`default_nettype none
module tfd_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] timer_in,
    output logic [7:0] timer_out,
    output logic [7:0] timer_oe,
    output logic [7:0] channel_interrupt,
    output logic irq
);
    logic pwr_r;
    logic [7:0] psc_r;
    logic [15:0] psc_cnt_r;
    logic [15:0] mask_a;
    logic [15:0] mask_b;
    logic tick_a;
    logic tick_b;
    logic [1:0] mode_r [8];
    logic [15:0] data_r [8];
    logic [15:0] count [8];
    logic [7:0] running;
    logic [7:0] zero_evt;
    logic [7:0] start_w;
    logic [7:0] stop_w;
    logic [7:0] ch_tick;
    logic [7:0] oen_r;
    logic [7:0] oval_r;
    logic [7:0] olvl_r;
    logic [7:0] omode_r;
    logic [7:0] ist_r;
    logic [7:0] imask_r;
    logic [7:0] pdir_r;
    logic [7:0] plat_r;
    logic [7:0] in_meta_r;
    logic [7:0] in_sync_r;
    logic setup;
    logic wr;
    logic unit_wr;
    logic [2:0] grp;
    logic [2:0] idx;
    logic [31:0] rd_data;
    logic rd_err;

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign pready = psel & penable;
    assign grp = paddr[7:5];
    assign idx = paddr[4:2];

    assign unit_wr = wr & pwr_r;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pwr_r <= 1'b0;
        end else if (wr && paddr == `TFD_ADDR_PWR) begin
            pwr_r <= pwdata[`TFD_PWR_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || !pwr_r) begin
            psc_r <= `TFD_RST_PSC;
        end else if (unit_wr && paddr == `TFD_ADDR_PSC) begin
            psc_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || !pwr_r) begin
            psc_cnt_r <= 16'h0000;
        end else begin
            psc_cnt_r <= psc_cnt_r + 16'h0001;
        end
    end

    // two shared count clocks
    // Division by 2^n keeps both ticks aligned to one counter
    always_comb begin
        mask_a = 16'((17'h00001 << psc_r[3:0]) - 17'h00001);
        mask_b = 16'((17'h00001 << psc_r[7:4]) - 17'h00001);
        tick_a = pwr_r & (&(psc_cnt_r | ~mask_a));
        tick_b = pwr_r & (&(psc_cnt_r | ~mask_b));
    end

    assign start_w = (unit_wr && paddr == `TFD_ADDR_START) ? pwdata[7:0] : 8'h00;
    assign stop_w = (unit_wr && paddr == `TFD_ADDR_STOP) ? pwdata[7:0] : 8'h00;

    always_ff @(posedge clock) begin
        for (int n = 0; n < 8; n++) begin
            if (!resetn || !pwr_r) begin
                mode_r[n] <= 2'h0;
            end else if (unit_wr && grp == `TFD_GRP_MODE && idx == 3'(n)
                         && paddr[1:0] == 2'h0 && !running[n]) begin
                mode_r[n] <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        for (int n = 0; n < 8; n++) begin
            if (!resetn || !pwr_r) begin
                data_r[n] <= 16'h0000;
            end else if (unit_wr && grp == `TFD_GRP_DATA && idx == 3'(n)
                         && paddr[1:0] == 2'h0) begin
                data_r[n] <= pwdata[15:0];
            end
        end
    end

    for (genvar g = 0; g < 8; g++) begin : g_ch
        assign ch_tick[g] = mode_r[g][`TFD_MODE_CKS_BIT] ? tick_b : tick_a;
        tfd_channel u_ch (
            .clock(clock),
            .resetn(resetn),
            .unit_on(pwr_r),
            .start(start_w[g]),
            .stop(stop_w[g]),
            .tick(ch_tick[g]),
            .start_irq_mode(mode_r[g][`TFD_MODE_MD_BIT]),
            .data(data_r[g]),
            .running(running[g]),
            .count(count[g]),
            .zero_evt(zero_evt[g])
        );
    end

    always_ff @(posedge clock) begin
        if (!resetn || !pwr_r) begin
            olvl_r <= 8'h00;
            omode_r <= 8'h00;
        end else begin
            if (unit_wr && paddr == `TFD_ADDR_OLVL) begin
                olvl_r <= (olvl_r & running) | (pwdata[7:0] & ~running);
            end
            if (unit_wr && paddr == `TFD_ADDR_OMODE) begin
                omode_r <= (omode_r & running) | (pwdata[7:0] & ~running);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || !pwr_r) begin
            oen_r <= 8'h00;
        end else if (unit_wr && paddr == `TFD_ADDR_OEN) begin
            oen_r <= pwdata[7:0];
        end
    end

    // output value
    // Only toggle mode is built; a set mode bit freezes the output
    always_ff @(posedge clock) begin
        if (!resetn || !pwr_r) begin
            oval_r <= 8'h00;
        end else if (unit_wr && paddr == `TFD_ADDR_OVAL) begin
            oval_r <= pwdata[7:0];
        end else begin
            oval_r <= oval_r ^ (zero_evt & oen_r & ~omode_r & ~olvl_r);
        end
    end

    // Port direction and latch stay with the port, not the unit
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pdir_r <= `TFD_RST_PDIR;
            plat_r <= `TFD_RST_PLAT;
        end else if (wr && paddr == `TFD_ADDR_PDIR) begin
            pdir_r <= pwdata[7:0];
        end else if (wr && paddr == `TFD_ADDR_PLAT) begin
            plat_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            timer_out <= 8'h00;
            timer_oe <= 8'h00;
        end else begin
            timer_out <= oval_r | plat_r;
            timer_oe <= ~pdir_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            in_meta_r <= 8'h00;
            in_sync_r <= 8'h00;
        end else begin
            in_meta_r <= timer_in;
            in_sync_r <= in_meta_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || !pwr_r) begin
            ist_r <= 8'h00;
        end else if (unit_wr && paddr == `TFD_ADDR_IST) begin
            ist_r <= (ist_r & ~pwdata[7:0]) | zero_evt;
        end else begin
            ist_r <= ist_r | zero_evt;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || !pwr_r) begin
            imask_r <= 8'h00;
        end else if (unit_wr && paddr == `TFD_ADDR_IMASK) begin
            imask_r <= pwdata[7:0];
        end
    end

    assign channel_interrupt = zero_evt;
    assign irq = |(ist_r & imask_r);

    always_comb begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            rd_err = 1'b1;
        end else if (grp == `TFD_GRP_MODE) begin
            rd_data = {30'h00000000, mode_r[idx]};
        end else if (grp == `TFD_GRP_DATA) begin
            rd_data = {16'h0000, data_r[idx]};
        end else if (grp == `TFD_GRP_CNT) begin
            rd_data = {16'h0000, count[idx]};
        end else if (grp == `TFD_GRP_STAT) begin
            rd_data = 32'h00000000;
        end else begin
            case (paddr)
                `TFD_ADDR_PWR: rd_data = {31'h00000000, pwr_r};
                `TFD_ADDR_PSC: rd_data = {24'h000000, psc_r};
                `TFD_ADDR_ENST: rd_data = {24'h000000, running};
                `TFD_ADDR_START: rd_data = 32'h00000000;
                `TFD_ADDR_STOP: rd_data = 32'h00000000;
                `TFD_ADDR_OEN: rd_data = {24'h000000, oen_r};
                `TFD_ADDR_OVAL: rd_data = {24'h000000, oval_r};
                `TFD_ADDR_OLVL: rd_data = {24'h000000, olvl_r};
                `TFD_ADDR_OMODE: rd_data = {24'h000000, omode_r};
                `TFD_ADDR_IST: rd_data = {24'h000000, ist_r};
                `TFD_ADDR_IMASK: rd_data = {24'h000000, imask_r};
                `TFD_ADDR_PDIR: rd_data = {24'h000000, pdir_r};
                `TFD_ADDR_PLAT: rd_data = {24'h000000, plat_r};
                `TFD_ADDR_PIN: rd_data = {24'h000000, in_sync_r};
                default: rd_err = 1'b1;
            endcase
        end
    end

    // Captured in setup so the access phase answers at once
    always_ff @(posedge clock) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_data;
            pslverr <= rd_err;
        end
    end

    sequence s_val_quiet;
        !(wr && paddr == `TFD_ADDR_OVAL) && pwr_r
        && !(wr && paddr == `TFD_ADDR_PWR);
    endsequence

    a_off_ignores: assert property (
        @(posedge clock) disable iff (!resetn)
        wr && !pwr_r && paddr == `TFD_ADDR_PSC |=> psc_r == `TFD_RST_PSC)
        else $error("write accepted while unit off");

    a_on_stopped: assert property (
        @(posedge clock) disable iff (!resetn)
        $rose(pwr_r) |-> running == 8'h00)
        else $error("channel running at power on");

    a_trig_zero: assert property (
        @(posedge clock) disable iff (!resetn)
        setup && !pwrite && paddr == `TFD_ADDR_START ##1 pready
        |-> prdata == 32'h00000000)
        else $error("start trigger read back nonzero");

    a_toggle_out: assert property (
        @(posedge clock) disable iff (!resetn)
        zero_evt[0] && oen_r[0] && !omode_r[0] && !olvl_r[0] ##0 s_val_quiet
        |=> oval_r[0] != $past(oval_r[0]) ##1 timer_out[0] == ($past(oval_r[0])
            | $past(plat_r[0])))
        else $error("zero detect did not toggle output");

    a_stop_keeps: assert property (
        @(posedge clock) disable iff (!resetn)
        stop_w[0] && !zero_evt[0] ##0 s_val_quiet |=> $stable(oval_r[0]))
        else $error("stop changed output level");

    a_pin_hiz: assert property (
        @(posedge clock) disable iff (!resetn)
        pdir_r[0] ##1 pdir_r[0] |-> !timer_oe[0])
        else $error("pin driven in input direction");

    a_irq_event: assert property (
        @(posedge clock) disable iff (!resetn)
        |(zero_evt & imask_r) && !(wr && paddr == `TFD_ADDR_IMASK) ##0 s_val_quiet
        |=> irq)
        else $error("unmasked event gave no interrupt");

    a_off_clears: assert property (
        @(posedge clock) disable iff (!resetn)
        $fell(pwr_r) |=> oval_r == 8'h00 && ist_r == 8'h00 && running == 8'h00)
        else $error("power off left unit state");

    a_sw_level: assert property (
        @(posedge clock) disable iff (!resetn)
        wr && pwr_r && paddr == `TFD_ADDR_OVAL |=> oval_r == $past(pwdata[7:0]))
        else $error("software output value not taken");

    a_pin_level: assert property (
        @(posedge clock) disable iff (!resetn)
        !pdir_r[0] && !plat_r[0] |=> timer_oe[0] && timer_out[0] == $past(oval_r[0]))
        else $error("pin does not show output level");

    a_mode_locked: assert property (
        @(posedge clock) disable iff (!resetn)
        unit_wr && grp == `TFD_GRP_MODE && idx == 3'h0 && running[0]
        |=> mode_r[0] == $past(mode_r[0]))
        else $error("mode changed while running");
endmodule // tfd_top
`default_nettype wire

// ===== tb/tfd_top_tb.sv
// Purpose: Self-checking bench for the eight channel timer unit over APB
// Assumes: Zero wait APB slave, prescaler tick every 2^n cycles
// Notes: Channel intervals are judged between events; only the start event is bounded from the start write
`include "tfd_map.svh"
`default_nettype none
module tfd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock;
    logic resetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] timer_in;
    logic [7:0] timer_out;
    logic [7:0] timer_oe;
    logic [7:0] channel_interrupt;
    logic irq;
    int err_count;
    int tests_run;
    int n;
    int k;
    logic [31:0] rd;
    logic [31:0] held;
    logic err;
    logic v1;
    logic v2;
    logic v3;

    tfd_top i_dut (
        .clock(clock),
        .resetn(resetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .timer_in(timer_in),
        .timer_out(timer_out),
        .timer_oe(timer_oe),
        .channel_interrupt(channel_interrupt),
        .irq(irq)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] bit32(input logic x);
        return {31'h0, x};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Counts: %0d comparisons, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
            output logic [31:0] rdata, output logic serr);
        int w;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clock);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge clock);
            w++;
        end while (pready !== 1'b1 && w < 16);
        check("apb ready", bit32(pready), 32'h1);
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
        apb(1'b1, addr, wdata, rd, err);
    endtask

    task automatic rchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0, rd, err);
        check(name, rd, exp);
    endtask

    // Pulses are one cycle wide, so look at falling edges
    task automatic wait_evt(input int ch, input int max, output int cnt);
        int i;
        cnt = 9999;
        for (i = 1; i <= max; i++) begin
            @(negedge clock);
            if (channel_interrupt[ch] === 1'b1) begin
                cnt = i;
                break;
            end
        end
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        $display("MISMATCH watchdog expected finish seen hang");
        summarize();
    end

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        timer_in = 8'h00;
        err_count = 0;
        tests_run = 0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(negedge clock);
        check("oe after reset", {24'h0, timer_oe}, 32'h0);
        wr(`TFD_ADDR_PSC, 32'h21);
        rchk("psc while off", `TFD_ADDR_PSC, 32'h0);
        wr(`TFD_ADDR_PWR, 32'h1);
        rchk("enable status at power on", `TFD_ADDR_ENST, 32'h0);
        wr(`TFD_ADDR_PSC, 32'h21);
        rchk("prescaler", `TFD_ADDR_PSC, 32'h21);
        for (k = 0; k < 8; k++) begin
            wr(8'h60 + 8'(4 * k), 32'h100 + 32'(k));
        end
        for (k = 0; k < 8; k++) begin
            rchk("data reg", 8'h60 + 8'(4 * k), 32'h100 + 32'(k));
        end
        $display("test done: power and setup");
        wr(8'h60, 32'h3);
        wr(`TFD_ADDR_OLVL, 32'h0);
        wr(`TFD_ADDR_OMODE, 32'h0);
        wr(`TFD_ADDR_OVAL, 32'h0);
        wr(`TFD_ADDR_OEN, 32'h1);
        wr(`TFD_ADDR_PLAT, 32'h0);
        wr(`TFD_ADDR_PDIR, 32'hfe);
        repeat (2) @(negedge clock);
        check("oe output dir", {24'h0, timer_oe}, 32'h1);
        wr(`TFD_ADDR_IMASK, 32'h1);
        wr(`TFD_ADDR_START, 32'h1);
        rchk("enable after start", `TFD_ADDR_ENST, 32'h1);
        rchk("start reads zero", `TFD_ADDR_START, 32'h0);
        wait_evt(0, 40, n);
        v1 = timer_out[0];
        wait_evt(0, 40, n);
        check("reload interval", 32'(n), 32'd8);
        v2 = timer_out[0];
        wait_evt(0, 40, n);
        v3 = timer_out[0];
        check("default level", bit32(v1), 32'h0);
        check("toggle at zero", bit32(v2), bit32(~v1));
        check("output period", bit32(v3), bit32(v1));
        check("irq on event", bit32(irq), 32'h1);
        apb(1'b0, 8'h80, 32'h0, rd, err);
        check("counter readable", bit32(rd <= 32'd3), 32'h1);
        wr(8'h60, 32'h1);
        // First event still ends an interval counted down from the old value
        wait_evt(0, 40, n);
        wait_evt(0, 40, n);
        wait_evt(0, 40, n);
        check("rewritten interval", 32'(n), 32'd4);
        $display("test done: divider run");
        wr(8'h48, 32'h2);
        wr(8'h68, 32'h1);
        wr(`TFD_ADDR_START, 32'h4);
        wait_evt(2, 40, n);
        wait_evt(2, 40, n);
        check("clock b interval", 32'(n), 32'd8);
        wr(8'h64, 32'h5);
        wr(8'h44, 32'h1);
        wr(`TFD_ADDR_START, 32'h2);
        wait_evt(1, 6, n);
        check("start event", bit32(n <= 6), 32'h1);
        wr(8'h44, 32'h0);
        rchk("mode locked", 8'h44, 32'h1);
        rchk("status unused", 8'ha0, 32'h0);
        rchk("three running", `TFD_ADDR_ENST, 32'h7);
        wr(`TFD_ADDR_STOP, 32'h7);
        rchk("enable after stop", `TFD_ADDR_ENST, 32'h0);
        rchk("stop reads zero", `TFD_ADDR_STOP, 32'h0);
        apb(1'b0, 8'h80, 32'h0, held, err);
        v1 = timer_out[0];
        repeat (20) @(posedge clock);
        rchk("counter held", 8'h80, held);
        check("output held", bit32(timer_out[0]), bit32(v1));
        $display("test done: start mode and stop");
        rchk("int status", `TFD_ADDR_IST, 32'h7);
        wr(`TFD_ADDR_IMASK, 32'h0);
        @(negedge clock);
        check("irq masked", bit32(irq), 32'h0);
        wr(`TFD_ADDR_IST, 32'h7);
        rchk("status cleared", `TFD_ADDR_IST, 32'h0);
        wr(`TFD_ADDR_IMASK, 32'h3);
        @(negedge clock);
        check("irq cleared", bit32(irq), 32'h0);
        wr(`TFD_ADDR_OEN, 32'h0);
        wr(`TFD_ADDR_OVAL, 32'h1);
        repeat (2) @(negedge clock);
        check("software level high", bit32(timer_out[0]), 32'h1);
        wr(`TFD_ADDR_OVAL, 32'h0);
        repeat (2) @(negedge clock);
        check("software level low", bit32(timer_out[0]), 32'h0);
        @(posedge clock);
        timer_in <= 8'ha5;
        repeat (4) @(posedge clock);
        rchk("input pins", `TFD_ADDR_PIN, 32'ha5);
        apb(1'b0, 8'h3c, 32'h0, rd, err);
        check("unmapped error", bit32(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("test done: interrupts and pins");
        wr(`TFD_ADDR_OVAL, 32'h1);
        wr(`TFD_ADDR_PWR, 32'h0);
        rchk("value cleared", `TFD_ADDR_OVAL, 32'h0);
        rchk("data cleared", 8'h60, 32'h0);
        rchk("enable cleared", `TFD_ADDR_OEN, 32'h0);
        rchk("direction kept", `TFD_ADDR_PDIR, 32'hfe);
        repeat (2) @(negedge clock);
        check("pin after off", bit32(timer_out[0]), 32'h0);
        $display("test done: power off");
        summarize();
    end
endmodule // tfd_top_tb
`default_nettype wire
